// *** core/jcc_cfg.svh ***
// constants of the test-port configuration loader
`ifndef JCC_CFG_SVH
`define JCC_CFG_SVH
`define JCC_IR_W 10
`define JCC_IR_CAPTURE 10'h001
`define JCC_OP_BYPASS 10'h3FF
`define JCC_OP_IDCODE 10'h006
`define JCC_OP_SAMPLE 10'h005
`define JCC_OP_PROGRAM 10'h002
`define JCC_OP_STATUS 10'h004
`define JCC_OP_IO_SETUP 10'h00D
`define JCC_OP_PARK 10'h2D0
`define JCC_OP_RESUME 10'h2B0
`define JCC_INIT_CYCLES 12'd3180
`define JCC_INIT_W 12
`define JCC_DR_W 32
`define JCC_STAT_W 5
`endif

// *** core/jcc_pkg.sv ***
// types of the test-port configuration loader
package jcc_pkg;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3, TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5,
    TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PAU_IR = 4'hD, TAP_EX2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } jcc_tap_state_type;
endpackage

// *** core/jcc_sync.sv ***
// three-stage synchroniser, change taken once stages two and three agree
module jcc_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic d,
  output logic q
);
  logic s1_reg, s2_reg, s3_reg, q_reg;
  logic q_next;

  always_comb begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
    if (!rst_n) begin
      q_next = INIT;
    end
  end

  always_ff @(posedge clk) begin
    s1_reg <= d;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    q_reg <= q_next;
  end

  assign q = q_reg;
endmodule

// *** core/jcc_tap.sv ***
// test-port state machine, moves on test-mode select at each test clock
module jcc_tap import jcc_pkg::*; (
  // test clock domain
  input wire logic tck,
  input wire logic rst_tck_n,
  input wire logic tms,
  // state
  output jcc_tap_state_type state
);
  jcc_tap_state_type state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      TAP_RESET: state_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: state_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: state_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: state_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: state_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    if (!rst_tck_n) begin
      state_next = TAP_RESET;
    end
  end

  always_ff @(posedge tck) begin
    state_reg <= state_next;
  end

  assign state = state_reg;
endmodule

// *** core/jcc_top.sv ***
// test-port configuration loader: scan chain, load, init, park/resume
`include "jcc_cfg.svh"
module jcc_top import jcc_pkg::*; #(
  parameter int BITSTREAM_BITS = 1024,
  parameter int IO_W = 8,
  parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001 // arbitrary value
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // configuration pins
  input wire logic chain_enable_n,
  output logic chain_enable_out_n,
  input wire logic reconfigure_request_n,
  output logic config_status_flag,
  output logic load_complete_flag,
  // global pins and user side
  input wire logic global_clear_n,
  input wire logic global_output_enable,
  output logic user_clear_n,
  output logic user_output_enable,
  // active configuration controller
  output logic active_ctrl_park,
  output logic abort_other_load,
  // io buffer setup
  output logic io_setup_active,
  output logic [IO_W-1:0] io_setup_data
);
  localparam int BW = $clog2(BITSTREAM_BITS + 1);

  // ---------------- test clock domain ----------------
  jcc_tap_state_type st;
  logic rst_tck_n, lc_tck;
  logic [`JCC_IR_W-1:0] ir_sr_reg, ir_sr_next, ir_reg, ir_next;
  logic [`JCC_DR_W-1:0] dr_sr_reg, dr_sr_next;
  logic bypass_reg, bypass_next;
  logic [BW-1:0] bit_cnt_reg, bit_cnt_next;
  logic [`JCC_INIT_W-1:0] init_cnt_reg, init_cnt_next;
  logic loading_reg, loading_next, initing_reg, initing_next;
  logic parked_reg, parked_next, io_mode_reg, io_mode_next;
  logic start_tgl_reg, start_tgl_next, done_tgl_reg, done_tgl_next;
  logic io_tgl_reg, io_tgl_next;
  logic [IO_W-1:0] io_hold_reg, io_hold_next;
  logic tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
  logic use_bypass;
  int dr_len;

  // reset into the test clock domain; the state machine itself is
  // never gated by configuration state, so the port always works
  jcc_sync #(.INIT(1'b0)) u_rst_sync (.clk(tck), .rst_n(1'b1),
    .d(reset_n), .q(rst_tck_n));
  jcc_sync #(.INIT(1'b0)) u_lc_sync (.clk(tck), .rst_n(rst_tck_n),
    .d(load_complete_flag), .q(lc_tck));
  jcc_tap u_tap (.tck(tck), .rst_tck_n(rst_tck_n), .tms(tms),
    .state(st));

  // unknown opcodes and the load itself run through the bypass cell
  always_comb begin
    use_bypass = 1'b0;
    dr_len = 1;
    unique case (ir_reg)
      `JCC_OP_IDCODE: dr_len = `JCC_DR_W;
      `JCC_OP_SAMPLE: dr_len = `JCC_STAT_W;
      `JCC_OP_STATUS: dr_len = 1;
      `JCC_OP_IO_SETUP: dr_len = IO_W;
      default: use_bypass = 1'b1;
    endcase
  end

  always_comb begin
    ir_sr_next = ir_sr_reg;
    ir_next = ir_reg;
    dr_sr_next = dr_sr_reg;
    bypass_next = bypass_reg;
    bit_cnt_next = bit_cnt_reg;
    init_cnt_next = init_cnt_reg;
    loading_next = loading_reg;
    initing_next = initing_reg;
    parked_next = parked_reg;
    io_mode_next = io_mode_reg;
    start_tgl_next = start_tgl_reg;
    done_tgl_next = done_tgl_reg;
    io_tgl_next = io_tgl_reg;
    io_hold_next = io_hold_reg;
    // init clocks count on every rising test-clock edge, whatever the state
    if (initing_reg) begin
      if (init_cnt_reg == `JCC_INIT_CYCLES - 12'd1) begin
        initing_next = 1'b0;
        done_tgl_next = ~done_tgl_reg;
      end else begin
        init_cnt_next = init_cnt_reg + 12'd1;
      end
    end
    unique case (st)
      TAP_RESET: ir_next = `JCC_OP_IDCODE;
      TAP_CAP_IR: ir_sr_next = `JCC_IR_CAPTURE;
      TAP_SH_IR: ir_sr_next = {tdi, ir_sr_reg[`JCC_IR_W-1:1]};
      TAP_UPD_IR: begin
        ir_next = ir_sr_reg;
        if (ir_sr_reg == `JCC_OP_PARK) begin
          parked_next = 1'b1;
        end
        if (ir_sr_reg == `JCC_OP_RESUME) begin
          parked_next = 1'b0;
          io_mode_next = 1'b0;
        end
        if (ir_sr_reg == `JCC_OP_IO_SETUP && parked_reg) begin
          io_mode_next = 1'b1;
        end
      end
      TAP_CAP_DR: begin
        bypass_next = 1'b0;
        dr_sr_next = '0;
        unique case (ir_reg)
          `JCC_OP_IDCODE: dr_sr_next = IDCODE_VALUE;
          `JCC_OP_SAMPLE: dr_sr_next[`JCC_STAT_W-1:0] =
            {parked_reg, io_mode_reg, loading_reg, initing_reg, lc_tck};
          `JCC_OP_STATUS: dr_sr_next[0] = lc_tck;
          `JCC_OP_IO_SETUP: dr_sr_next[IO_W-1:0] = io_hold_reg;
          default: dr_sr_next = '0;
        endcase
      end
      TAP_SH_DR: begin
        bypass_next = tdi;
        dr_sr_next = dr_sr_reg >> 1;
        dr_sr_next[dr_len-1] = tdi;
        if (ir_reg == `JCC_OP_PROGRAM) begin
          if (!loading_reg) begin
            // a fresh load stops any init under way
            loading_next = 1'b1;
            initing_next = 1'b0;
            start_tgl_next = ~start_tgl_reg;
            bit_cnt_next = BW'(1);
          end else if (bit_cnt_reg == BW'(BITSTREAM_BITS - 1)) begin
            loading_next = 1'b0;
            initing_next = 1'b1;
            init_cnt_next = '0;
          end else begin
            bit_cnt_next = bit_cnt_reg + BW'(1);
          end
        end
      end
      TAP_UPD_DR: begin
        if (ir_reg == `JCC_OP_IO_SETUP && io_mode_reg) begin
          io_hold_next = dr_sr_reg[IO_W-1:0];
          io_tgl_next = ~io_tgl_reg;
        end
      end
      default: ;
    endcase
    if (!rst_tck_n) begin
      ir_sr_next = '0;
      ir_next = `JCC_OP_IDCODE;
      dr_sr_next = '0;
      bypass_next = 1'b0;
      bit_cnt_next = '0;
      init_cnt_next = '0;
      loading_next = 1'b0;
      initing_next = 1'b0;
      parked_next = 1'b0;
      io_mode_next = 1'b0;
      start_tgl_next = 1'b0;
      done_tgl_next = 1'b0;
      io_tgl_next = 1'b0;
      io_hold_next = '0;
    end
  end

  always_ff @(posedge tck) begin
    ir_sr_reg <= ir_sr_next;
    ir_reg <= ir_next;
    dr_sr_reg <= dr_sr_next;
    bypass_reg <= bypass_next;
    bit_cnt_reg <= bit_cnt_next;
    init_cnt_reg <= init_cnt_next;
    loading_reg <= loading_next;
    initing_reg <= initing_next;
    parked_reg <= parked_next;
    io_mode_reg <= io_mode_next;
    start_tgl_reg <= start_tgl_next;
    done_tgl_reg <= done_tgl_next;
    io_tgl_reg <= io_tgl_next;
    io_hold_reg <= io_hold_next;
  end

  // output changes on the falling edge, released outside shift states
  always_comb begin
    tdo_next = tdo_reg;
    tdo_oe_next = 1'b0;
    if (st == TAP_SH_IR) begin
      tdo_next = ir_sr_reg[0];
      tdo_oe_next = 1'b1;
    end else if (st == TAP_SH_DR) begin
      tdo_next = use_bypass ? bypass_reg : dr_sr_reg[0];
      tdo_oe_next = 1'b1;
    end
    if (!rst_tck_n) begin
      tdo_next = 1'b0;
      tdo_oe_next = 1'b0;
    end
  end

  always_ff @(negedge tck) begin
    tdo_reg <= tdo_next;
    tdo_oe_reg <= tdo_oe_next;
  end

  assign tdo = tdo_reg;
  assign tdo_oe = tdo_oe_reg;

  // ---------------- system clock domain ----------------
  logic start_s, done_s, park_s, io_s, iot_s, reconf_s, ce_s;
  logic goe_s, gclr_s;
  logic start_prev_reg, done_prev_reg, iot_prev_reg;
  logic lc_reg, lc_next, abort_reg, abort_next;
  logic [IO_W-1:0] io_data_reg, io_data_next;
  logic start_ev, done_ev;

  jcc_sync #(.INIT(1'b0)) u_st_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(start_tgl_reg), .q(start_s));
  jcc_sync #(.INIT(1'b0)) u_dn_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(done_tgl_reg), .q(done_s));
  jcc_sync #(.INIT(1'b0)) u_pk_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(parked_reg), .q(park_s));
  jcc_sync #(.INIT(1'b0)) u_io_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(io_mode_reg), .q(io_s));
  jcc_sync #(.INIT(1'b0)) u_it_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(io_tgl_reg), .q(iot_s));
  jcc_sync #(.INIT(1'b1)) u_rc_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(reconfigure_request_n), .q(reconf_s));
  jcc_sync #(.INIT(1'b1)) u_ce_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(chain_enable_n), .q(ce_s));
  jcc_sync #(.INIT(1'b0)) u_oe_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(global_output_enable), .q(goe_s));
  jcc_sync #(.INIT(1'b1)) u_cl_sync (.clk(clk_sys), .rst_n(reset_n),
    .d(global_clear_n), .q(gclr_s));

  assign start_ev = start_s ^ start_prev_reg;
  assign done_ev = done_s ^ done_prev_reg;

  always_comb begin
    lc_next = lc_reg;
    abort_next = abort_reg;
    io_data_next = io_data_reg;
    // reconfigure drops the flag, completion beats it, a start beats both
    if (!reconf_s) begin
      lc_next = 1'b0;
    end
    if (done_ev) begin
      abort_next = 1'b0;
      lc_next = !ce_s;
    end
    if (start_ev) begin
      lc_next = 1'b0;
      abort_next = 1'b1;
    end
    // io words move only on a synchronised update toggle
    if (iot_s != iot_prev_reg) begin
      io_data_next = io_hold_reg;
    end
    if (!reset_n) begin
      lc_next = 1'b0;
      abort_next = 1'b0;
      io_data_next = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    start_prev_reg <= reset_n ? start_s : 1'b0;
    done_prev_reg <= reset_n ? done_s : 1'b0;
    iot_prev_reg <= reset_n ? iot_s : 1'b0;
    lc_reg <= lc_next;
    abort_reg <= abort_next;
    io_data_reg <= io_data_next;
    config_status_flag <= reset_n ? reconf_s : 1'b1;
    active_ctrl_park <= reset_n ? park_s : 1'b0;
    io_setup_active <= reset_n ? io_s : 1'b0;
    chain_enable_out_n <= reset_n ? !lc_reg : 1'b1;
    // global pins reach user logic only, never the test side
    user_clear_n <= reset_n ? gclr_s : 1'b1;
    user_output_enable <= reset_n ? (goe_s && lc_reg && !io_s) : 1'b0;
  end

  assign load_complete_flag = lc_reg;
  assign abort_other_load = abort_reg;
  assign io_setup_data = io_data_reg;

  // ---------------- checks ----------------
  chk_bypass_delay: assert property (@(posedge tck) disable iff (!rst_tck_n)
    $past(st) == TAP_SH_DR |-> bypass_reg == $past(tdi))
    else $error("bypass cell did not carry input one clock later");
  chk_bypass_clean: assert property (@(posedge tck) disable iff (!rst_tck_n)
    ir_reg == `JCC_OP_BYPASS && st != TAP_UPD_IR
    |=> $stable(bit_cnt_reg) && $stable(parked_reg))
    else $error("bypass touched internal state");
  chk_safe_instr: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (ir_reg == `JCC_OP_IDCODE || ir_reg == `JCC_OP_SAMPLE) && loading_reg
    |=> loading_reg && $stable(bit_cnt_reg))
    else $error("safe instruction disturbed the load");
  chk_init_length: assert property (@(posedge tck) disable iff (!rst_tck_n)
    initing_reg && init_cnt_reg == `JCC_INIT_CYCLES - 12'd1
    |=> done_tgl_reg != $past(done_tgl_reg) && !initing_reg)
    else $error("init did not end after the set clock count");
  chk_io_needs_park: assert property (@(posedge tck) disable iff (!rst_tck_n)
    io_mode_reg |-> parked_reg)
    else $error("io setup active without park");
  chk_status_read: assert property (@(posedge tck) disable iff (!rst_tck_n)
    st == TAP_CAP_DR && ir_reg == `JCC_OP_STATUS |=> dr_sr_reg[0] ==
    $past(lc_tck))
    else $error("status capture does not show the flag");
  chk_flag_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    start_ev |=> !load_complete_flag && abort_other_load)
    else $error("flag or abort wrong at load start");
  chk_flag_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
    done_ev && !ce_s |=> load_complete_flag)
    else $error("flag not raised after init");
  chk_status_free: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reconf_s ##1 reconf_s |-> config_status_flag)
    else $error("status flag held low without reconfigure request");
  chk_park_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    park_s != active_ctrl_park |=> park_s == active_ctrl_park)
    else $error("park output does not follow parked state");
  cov_bypass: cover property (@(posedge tck) disable iff (!rst_tck_n)
    ir_reg == `JCC_OP_BYPASS && st == TAP_SH_DR);
  cov_load_done: cover property (@(posedge clk_sys) disable iff (!reset_n)
    !load_complete_flag ##1 load_complete_flag);
  cov_park_io: cover property (@(posedge tck) disable iff (!rst_tck_n)
    parked_reg && io_mode_reg);
endmodule

// *** bench/jcc_host.sv ***
// model of the programming host that drives the test port
module jcc_host (
  // test port, host side
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 40;
  logic q_bit;
  // clock stands still outside frames, lines rest at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // inputs change after the falling edge, tdo taken at the rising one
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #HALF tck = 1'b1;
    q_bit = tdo;
    #HALF tck = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b1);
    tms = 1'b1;
  endtask
  // from idle through one IR or DR scan, lsb first, back to idle
  task automatic scan(input logic is_ir, input logic [31:0] d,
      input int n, output logic [31:0] q);
    q = '0;
    step(1'b1, 1'b1);
    if (is_ir) step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i]);
      q[i] = q_bit;
    end
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    tms = 1'b1;
  endtask
endmodule

// *** bench/jtag_configuration_control_bench.sv ***
// self-checking bench of the test-port configuration loader
`include "jcc_cfg.svh"
module jtag_configuration_control_bench import jcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short bitstream keeps the run brief
  localparam int BITS = 16;
  localparam logic [31:0] ID_VAL = 32'h0000_5A5B; // arbitrary value
  // test clocks from the last bitstream bit up to the closing idle
  localparam int POST_SCAN = 81;
  logic clk_sys, reset_n, tck, tms, tdi, tdo, tdo_oe;
  logic chain_enable_n, chain_enable_out_n, reconfigure_request_n;
  logic config_status_flag, load_complete_flag;
  logic global_clear_n, global_output_enable, user_clear_n;
  logic user_output_enable, active_ctrl_park, abort_other_load;
  logic io_setup_active;
  logic [7:0] io_setup_data;
  logic [3:0] scheme_select_pins;
  logic [31:0] q;
  int err_count, samples_checked;

  jcc_top #(.BITSTREAM_BITS(BITS), .IO_W(8), .IDCODE_VALUE(ID_VAL)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .chain_enable_n(chain_enable_n),
    .chain_enable_out_n(chain_enable_out_n),
    .reconfigure_request_n(reconfigure_request_n),
    .config_status_flag(config_status_flag),
    .load_complete_flag(load_complete_flag),
    .global_clear_n(global_clear_n),
    .global_output_enable(global_output_enable),
    .user_clear_n(user_clear_n), .user_output_enable(user_output_enable),
    .active_ctrl_park(active_ctrl_park),
    .abort_other_load(abort_other_load),
    .io_setup_active(io_setup_active), .io_setup_data(io_setup_data)
  );
  jcc_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a few test clocks plus system clocks let crossings land
  task automatic settle();
    u_host.idle(4);
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic ir(input logic [9:0] op);
    u_host.scan(1'b1, {22'h0, op}, `JCC_IR_W, q);
    check("ir capture", q[9:0], `JCC_IR_CAPTURE);
  endtask
  task automatic dr(input logic [31:0] d, input int n);
    u_host.scan(1'b0, d, n, q);
  endtask

  task automatic t_bypass();
    logic [9:0] ops[2];
    ops[0] = `JCC_OP_BYPASS;
    ops[1] = 10'h155;
    foreach (ops[k]) begin
      ir(ops[k]);
      dr(32'h0000_00B5, 8);
      check("bypass out", q[7:0], 8'h6A);
    end
    ir(`JCC_OP_IDCODE);
    dr(32'h0, 32);
    check("idcode", q, ID_VAL);
  endtask

  task automatic t_load(input logic ok);
    @(posedge clk_sys);
    chain_enable_n <= ~ok;
    ir(`JCC_OP_PROGRAM);
    dr(32'h0000_00C3, BITS / 2);
    repeat (10) @(negedge clk_sys);
    check("abort at start", abort_other_load, 1'b1);
    check("flag at start", load_complete_flag, 1'b0);
    // safe instructions between the two halves of the bitstream
    ir(`JCC_OP_IDCODE);
    dr(32'h0, 32);
    check("idcode in load", q, ID_VAL);
    ir(`JCC_OP_SAMPLE);
    dr(32'h0, 5);
    check("sample in load", q[4:0], 5'b00100);
    ir(`JCC_OP_PROGRAM);
    dr(32'h0000_00A5, BITS / 2);
    ir(`JCC_OP_IDCODE);
    dr(32'h0, 32);
    check("idcode in init", q, ID_VAL);
    ir(`JCC_OP_SAMPLE);
    dr(32'h0, 5);
    check("sample in init", q[4:0], 5'b00010);
    // one clock short of the init count, then the last one
    u_host.idle(int'(`JCC_INIT_CYCLES) - 1 - POST_SCAN);
    repeat (10) @(negedge clk_sys);
    check("flag in init", load_complete_flag, 1'b0);
    u_host.idle(1);
    repeat (10) @(negedge clk_sys);
    check("flag after init", load_complete_flag, ok);
    check("chain out", chain_enable_out_n, !ok);
    check("abort at end", abort_other_load, 1'b0);
    check("user oe", user_output_enable, ok);
    ir(`JCC_OP_STATUS);
    dr(32'h0, 1);
    check("status scan", q[0], ok);
  endtask

  task automatic t_park();
    ir(`JCC_OP_IO_SETUP);
    settle();
    check("io without park", io_setup_active, 1'b0);
    ir(`JCC_OP_PARK);
    settle();
    check("parked", active_ctrl_park, 1'b1);
    ir(`JCC_OP_IO_SETUP);
    settle();
    check("io mode", io_setup_active, 1'b1);
    check("status in io", config_status_flag, 1'b1);
    check("user oe in io", user_output_enable, 1'b0);
    dr(32'h0000_00C3, 8);
    settle();
    check("io data", io_setup_data, 8'hC3);
    ir(`JCC_OP_RESUME);
    settle();
    check("resumed", active_ctrl_park, 1'b0);
    check("io left", io_setup_active, 1'b0);
  endtask

  task automatic t_global();
    @(posedge clk_sys);
    global_clear_n <= 1'b0;
    global_output_enable <= 1'b0;
    ir(`JCC_OP_IDCODE);
    dr(32'h0, 32);
    check("idcode in clear", q, ID_VAL);
    repeat (10) @(negedge clk_sys);
    check("user clear", user_clear_n, 1'b0);
    check("user oe off", user_output_enable, 1'b0);
    check("flag in clear", load_complete_flag, 1'b1);
    @(posedge clk_sys);
    global_clear_n <= 1'b1;
    global_output_enable <= 1'b1;
    repeat (10) @(negedge clk_sys);
    check("user clear off", user_clear_n, 1'b1);
  endtask

  task automatic t_reconfig();
    @(posedge clk_sys);
    reconfigure_request_n <= 1'b0;
    repeat (10) @(negedge clk_sys);
    check("status on request", config_status_flag, 1'b0);
    check("flag on request", load_complete_flag, 1'b0);
    @(posedge clk_sys);
    reconfigure_request_n <= 1'b1;
    repeat (10) @(negedge clk_sys);
    check("status restored", config_status_flag, 1'b1);
  endtask

  // generous bound, the two loads take well under a millisecond
  initial begin
    #2ms;
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    chain_enable_n = 1'b0;
    reconfigure_request_n = 1'b1;
    scheme_select_pins = 4'h0;
    global_clear_n = 1'b1;
    global_output_enable = 1'b1;
    // test domain needs running test clocks to see the reset
    fork
      repeat (6) @(posedge clk_sys);
      repeat (8) u_host.step(1'b1, 1'b1);
    join
    @(negedge clk_sys);
    check("reset status", config_status_flag, 1'b1);
    check("reset flag", load_complete_flag, 1'b0);
    check("reset chain out", chain_enable_out_n, 1'b1);
    check("reset tdo oe", tdo_oe, 1'b0);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) u_host.step(1'b1, 1'b1);
    u_host.idle(1);
    t_bypass();
    t_load(1'b0);
    t_load(1'b1);
    t_park();
    t_global();
    t_reconfig();
    end_of_test();
  end
endmodule
